// ===== rtl/tmio_defines.vh
`ifndef TMIO_DEFINES_VH
`define TMIO_DEFINES_VH

// I/O addresses of the port registers.
`define TMIO_ADDR_W 6
`define TMIO_ADR_D_LEVEL 6'h10
`define TMIO_ADR_D_DIR 6'h11
`define TMIO_ADR_D_OUT 6'h12
`define TMIO_ADR_B_LEVEL 6'h16
`define TMIO_ADR_A_LEVEL 6'h19
`define TMIO_ADR_A_CTRL 6'h1a
`define TMIO_ADR_A_OUT 6'h1b
`define TMIO_ADR_MCU_CS 6'h07
`define TMIO_ADR_BIT_MAX 6'h1f

// Field positions.
`define TMIO_A_HC_BIT 2
`define TMIO_CS_PULLUP_BIT 7

// Masks of implemented bits.
`define TMIO_A_MASK 8'h0f
`define TMIO_A_LEVEL_MASK 4'hb

// Reset values.
`define TMIO_RST_BYTE 8'h00

// Shortest external reset low time in ns, and its cycle count at 125 MHz.
`define TMIO_RST_MIN_NS 50
`define TMIO_CLK_PERIOD_NS 8
`define TMIO_RST_MIN_CYC ((`TMIO_RST_MIN_NS + `TMIO_CLK_PERIOD_NS - 1) / `TMIO_CLK_PERIOD_NS)

`endif

// ===== rtl/tmio_ports.v
`timescale 1ns/10ps
`include "tmio_defines.vh"
// Summary of operation
// (RL1) Port A four pins, bit2 output LED sink
// (RL2) Port A bits 3,1,0 bidirectional, own pull-ups
// (RL3) Port B input-only, one shared pull-up select
// (RL4) Special function on B pin kills pull-up
// (RL5) Port D bidirectional, per-pin pull-ups
// (RL6) All pins tristate asynchronously during reset
// (RL7) Reset low beyond 50 ns resets device
// (RL8) Port A output register at 0x1B
// (RL9) Port A control at 0x1A, direction and HC
// (RL10) Port A level register at 0x19
// (RL11) Port B level register at 0x16
// (RL12) Port D registers at 0x12, 0x11, 0x10
// (RL13) Shared B pull-up is bit7 at 0x07
// (RL14) Bit set/clear reach 0x00 to 0x1F only
// (RL15) Master writes zero to reserved bits
// (RL16) Direction one drives; else output bit pulls up
module tmio_ports #(
    parameter ADDR_W = `TMIO_ADDR_W
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [ADDR_W-1:0] io_addr_i,
    input wire io_wr_i,
    input wire io_rd_i,
    input wire [7:0] io_wdata_i,
    input wire bit_set_instruction_i,
    input wire bit_clear_instruction_i,
    input wire [2:0] bit_sel_i,
    output reg [7:0] io_rdata_o,
    output reg io_bit_err_o,
    input wire [3:0] port_a_pin_i,
    output reg [3:0] port_a_pin_o,
    output reg [3:0] port_a_pin_oe_o,
    output reg [3:0] port_a_pullup_o,
    output reg led_sink_high_current_o,
    input wire [7:0] port_b_pin_i,
    input wire [7:0] port_b_special_en_i,
    output reg [7:0] port_b_pullup_o,
    input wire [7:0] port_d_pin_i,
    output reg [7:0] port_d_pin_o,
    output reg [7:0] port_d_pin_oe_o,
    output reg [7:0] port_d_pullup_o
);

    reg [3:0] first_port_output_reg;
    reg [3:0] first_port_control_reg;
    reg [7:0] third_port_output_reg;
    reg [7:0] third_port_direction_reg;
    reg second_port_pullup_enable;

    reg [3:0] a_out_next;
    reg [3:0] a_ctrl_next;
    reg [7:0] d_out_next;
    reg [7:0] d_dir_next;
    reg pullup_next;
    reg [7:0] rdata_next;
    reg bit_err_next;
    reg [7:0] cur_val;
    reg [7:0] wr_val;
    reg wr_en;

    wire [7:0] a_level;
    wire [7:0] b_level;
    wire [7:0] d_level;
    wire [7:0] cs_val;
    wire bit_op;
    wire bit_ok;

    // Set or clear one bit of a byte as a read-modify-write.
    function [7:0] tmio_bit_mod;
        input [7:0] value;
        input [2:0] pos;
        input set;
        reg [7:0] mask;
        begin
            mask = 8'h01 << pos;
            if (set) begin
                tmio_bit_mod = value | mask;
            end else begin
                tmio_bit_mod = value & ~mask;
            end
        end
    endfunction

    // (RL10) Live A levels.
    assign a_level = {4'h0, port_a_pin_i & `TMIO_A_LEVEL_MASK};
    // (RL11) Live B levels.
    assign b_level = port_b_pin_i;
    // (RL12) Live D levels.
    assign d_level = port_d_pin_i;
    // (RL13) Pull-up bit in status.
    assign cs_val = {second_port_pullup_enable, 7'h00};

    assign bit_op = bit_set_instruction_i | bit_clear_instruction_i;
    // (RL14) Bit range check.
    assign bit_ok = (io_addr_i <= `TMIO_ADR_BIT_MAX);

    always @* begin
        cur_val = `TMIO_RST_BYTE;
        case (io_addr_i)
            // (RL8) A output readback.
            `TMIO_ADR_A_OUT: cur_val = {4'h0, first_port_output_reg};
            // (RL9) A control readback.
            `TMIO_ADR_A_CTRL: cur_val = {4'h0, first_port_control_reg};
            `TMIO_ADR_A_LEVEL: cur_val = a_level;
            `TMIO_ADR_B_LEVEL: cur_val = b_level;
            `TMIO_ADR_D_OUT: cur_val = third_port_output_reg;
            `TMIO_ADR_D_DIR: cur_val = third_port_direction_reg;
            `TMIO_ADR_D_LEVEL: cur_val = d_level;
            `TMIO_ADR_MCU_CS: cur_val = cs_val;
            default: cur_val = `TMIO_RST_BYTE;
        endcase
    end

    always @* begin
        a_out_next = first_port_output_reg;
        a_ctrl_next = first_port_control_reg;
        d_out_next = third_port_output_reg;
        d_dir_next = third_port_direction_reg;
        pullup_next = second_port_pullup_enable;
        rdata_next = io_rdata_o;
        bit_err_next = 1'b0;
        wr_val = io_wdata_i;
        wr_en = 1'b0;
        if (bit_op) begin
            // (RL14) Bit ops outside range refused.
            if (bit_ok) begin
                wr_val = tmio_bit_mod(cur_val, bit_sel_i,
                                      bit_set_instruction_i);
                wr_en = 1'b1;
            end else begin
                bit_err_next = 1'b1;
            end
        end else if (io_wr_i) begin
            wr_en = 1'b1;
        end else if (io_rd_i) begin
            rdata_next = cur_val;
        end
        if (wr_en) begin
            case (io_addr_i)
                // (RL8) A output write.
                `TMIO_ADR_A_OUT: a_out_next = wr_val[3:0];
                // (RL9) A direction and high-current write.
                `TMIO_ADR_A_CTRL: a_ctrl_next = wr_val[3:0];
                // (RL12) D output write.
                `TMIO_ADR_D_OUT: d_out_next = wr_val;
                // (RL12) D direction write.
                `TMIO_ADR_D_DIR: d_dir_next = wr_val;
                // (RL13) Shared pull-up write.
                `TMIO_ADR_MCU_CS:
                    pullup_next = wr_val[`TMIO_CS_PULLUP_BIT];
                default: pullup_next = second_port_pullup_enable;
            endcase
        end
    end

    // Pull-up of an input pin whose output bit is one.
    function [7:0] tmio_pullup;
        input [7:0] dir;
        input [7:0] out;
        begin
            tmio_pullup = ~dir & out;
        end
    endfunction

    // The LED sink pin drives whenever the block is out of reset.
    function [3:0] tmio_a_oe;
        input [3:0] ctrl;
        begin
            tmio_a_oe = (ctrl & `TMIO_A_LEVEL_MASK) | 4'h4;
        end
    endfunction

    // A pin with its special function on never gets the pull-up.
    function [7:0] tmio_b_pullup;
        input shared;
        input [7:0] special;
        begin
            tmio_b_pullup = {8{shared}} & ~special;
        end
    endfunction

    // Next values of the pin outputs.
    wire [3:0] a_oe_next;
    wire [7:0] a_pu_wide;
    wire [3:0] a_pu_next;
    wire a_hc_next;
    wire [7:0] b_pu_next;
    wire [7:0] d_pu_next;

    // (RL1) Bit 2 always driven.
    assign a_oe_next = tmio_a_oe(a_ctrl_next);
    // (RL2) Per-bit A pull-ups.
    assign a_pu_wide = tmio_pullup({4'h0, a_ctrl_next}, {4'h0, a_out_next});
    assign a_pu_next = a_pu_wide[3:0] & `TMIO_A_LEVEL_MASK;
    // (RL1) High-current sink enable.
    assign a_hc_next = a_ctrl_next[`TMIO_A_HC_BIT];
    // (RL4) Special function kills pull-up.
    assign b_pu_next = tmio_b_pullup(pullup_next, port_b_special_en_i);
    // (RL5) Per-pin D pull-ups.
    assign d_pu_next = tmio_pullup(d_dir_next, d_out_next);

    // (RL7) Every register resets asynchronously, clock or not.
    // (RL8) A output register.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_port_output_reg <= 4'h0;
        end else begin
            first_port_output_reg <= a_out_next;
        end
    end

    // (RL9) A control register.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_port_control_reg <= 4'h0;
        end else begin
            first_port_control_reg <= a_ctrl_next;
        end
    end

    // (RL12) D output register.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            third_port_output_reg <= `TMIO_RST_BYTE;
        end else begin
            third_port_output_reg <= d_out_next;
        end
    end

    // (RL12) D direction register.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            third_port_direction_reg <= `TMIO_RST_BYTE;
        end else begin
            third_port_direction_reg <= d_dir_next;
        end
    end

    // (RL13) Shared B pull-up enable.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            second_port_pullup_enable <= 1'b0;
        end else begin
            second_port_pullup_enable <= pullup_next;
        end
    end

    // Read data holds until the next read.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_rdata_o <= `TMIO_RST_BYTE;
        end else begin
            io_rdata_o <= rdata_next;
        end
    end

    // (RL14) Out-of-range bit op flag.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_bit_err_o <= 1'b0;
        end else begin
            io_bit_err_o <= bit_err_next;
        end
    end

    // (RL6) A drive value, released in reset.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_a_pin_o <= 4'h0;
        end else begin
            port_a_pin_o <= a_out_next;
        end
    end

    // (RL6) A drive enables off in reset.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_a_pin_oe_o <= 4'h0;
        end else begin
            port_a_pin_oe_o <= a_oe_next;
        end
    end

    // (RL2) A pull-up outputs.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_a_pullup_o <= 4'h0;
        end else begin
            port_a_pullup_o <= a_pu_next;
        end
    end

    // (RL1) LED sink current select.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            led_sink_high_current_o <= 1'b0;
        end else begin
            led_sink_high_current_o <= a_hc_next;
        end
    end

    // (RL3) Shared B pull-ups.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_b_pullup_o <= `TMIO_RST_BYTE;
        end else begin
            port_b_pullup_o <= b_pu_next;
        end
    end

    // (RL16) D drive value.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_d_pin_o <= `TMIO_RST_BYTE;
        end else begin
            port_d_pin_o <= d_out_next;
        end
    end

    // (RL16) D drive enables.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_d_pin_oe_o <= `TMIO_RST_BYTE;
        end else begin
            port_d_pin_oe_o <= d_dir_next;
        end
    end

    // (RL5) D pull-up outputs.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_d_pullup_o <= `TMIO_RST_BYTE;
        end else begin
            port_d_pullup_o <= d_pu_next;
        end
    end

endmodule

// ===== tb/tmio_asserts.sv
`timescale 1ns/10ps
module tmio_asserts (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [5:0] io_addr_i,
    input wire io_wr_i,
    input wire [7:0] io_wdata_i,
    input wire bit_set_instruction_i,
    input wire bit_clear_instruction_i,
    input wire io_bit_err_o,
    input wire [7:0] port_d_pin_o,
    input wire [7:0] port_d_pin_oe_o,
    input wire [7:0] port_d_pullup_o
);
    wire bit_op = bit_set_instruction_i || bit_clear_instruction_i;
    wire bad_bit = bit_op && io_addr_i > 6'h1f;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr(a);
        !bit_op && io_wr_i && io_addr_i == a;
    endsequence
    property p_rst_z; disable iff (1'b0) !rst_n_i |-> port_d_pin_oe_o == 8'h00;
    endproperty
    a_rst_z: assert property (p_rst_z) else $error("d driven");
    property p_pu_d; port_d_pullup_o == (~port_d_pin_oe_o & port_d_pin_o);
    endproperty
    a_pu_d: assert property (p_pu_d) else $error("d pull");
    property p_wr_dir; s_wr(6'h11) |=> port_d_pin_oe_o == $past(io_wdata_i);
    endproperty
    a_wr_dir: assert property (p_wr_dir) else $error("d dir");
    property p_wr_out; s_wr(6'h12) |=> port_d_pin_o == $past(io_wdata_i);
    endproperty
    a_wr_out: assert property (p_wr_out) else $error("d out");
    property p_ro; s_wr(6'h10) |=> $stable(port_d_pin_oe_o);
    endproperty
    a_ro: assert property (p_ro) else $error("d level write");
    property p_hold; !bit_op && !io_wr_i |=> $stable(port_d_pin_o);
    endproperty
    a_hold: assert property (p_hold) else $error("d out moved");
    property p_err; $past(rst_n_i) |-> io_bit_err_o == $past(bad_bit);
    endproperty
    a_err: assert property (p_err) else $error("bit range");
    property p_far; bad_bit |=> $stable(port_d_pin_o);
    endproperty
    a_far: assert property (p_far) else $error("far bit op");
endmodule

bind tmio_ports tmio_asserts u_chk (.clk_sys_i, .rst_n_i, .io_addr_i,
    .io_wr_i, .io_wdata_i, .bit_set_instruction_i, .bit_clear_instruction_i,
    .io_bit_err_o, .port_d_pin_o, .port_d_pin_oe_o, .port_d_pullup_o);

// ===== tb/tmio_board.sv
`timescale 1ns/10ps
module tmio_board #(parameter W = 8) (
    input wire [W-1:0] drv_i,
    input wire [W-1:0] oe_i,
    input wire [W-1:0] pu_i,
    input wire [W-1:0] ext_i,
    output wire [W-1:0] lvl_o
);
    // A released pin settles at its pull-up, else at the board level.
    assign lvl_o = (oe_i & drv_i) | (~oe_i & (pu_i | ext_i));
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk_sys_i = 0, rst_n_i = 0, io_bit_err_o, led_sink_high_current_o;
    logic io_wr_i, io_rd_i, bit_set_instruction_i, bit_clear_instruction_i;
    logic [5:0] io_addr_i = 0;
    logic [2:0] bit_sel_i = 0;
    logic [3:0] req = 0, port_a_pin_o, port_a_pin_oe_o, port_a_pullup_o;
    logic [7:0] io_wdata_i = 0, io_rdata_o, port_b_special_en_i = 0;
    logic [7:0] port_b_pullup_o, port_d_pin_o, port_d_pin_oe_o;
    logic [7:0] port_d_pullup_o, ext_d = 0, ext_b = 0;
    wire [7:0] port_b_pin_i, port_d_pin_i;
    wire [3:0] port_a_pin_i;
    int checked = 0, mismatches = 0;
    assign {io_wr_i, io_rd_i, bit_set_instruction_i,
        bit_clear_instruction_i} = req;
    tmio_ports DUT (.clk_sys_i, .rst_n_i, .io_addr_i, .io_wr_i, .io_rd_i,
        .io_wdata_i, .bit_set_instruction_i, .bit_clear_instruction_i,
        .bit_sel_i, .io_rdata_o, .io_bit_err_o, .port_a_pin_i, .port_a_pin_o,
        .port_a_pin_oe_o, .port_a_pullup_o, .led_sink_high_current_o,
        .port_b_pin_i, .port_b_special_en_i, .port_b_pullup_o, .port_d_pin_i,
        .port_d_pin_o, .port_d_pin_oe_o, .port_d_pullup_o);
    tmio_board #(.W(20)) u_brd (.drv_i({port_d_pin_o, 8'h00, port_a_pin_o}),
        .oe_i({port_d_pin_oe_o, 8'h00, port_a_pin_oe_o}),
        .pu_i({port_d_pullup_o, port_b_pullup_o, port_a_pullup_o}),
        .ext_i({ext_d, ext_b, 4'h0}),
        .lvl_o({port_d_pin_i, port_b_pin_i, port_a_pin_i}));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    initial begin
        repeat (500) @(posedge clk_sys_i);
        mismatches++;
        stop_test;
    end
    // Kind 0 write, 1 read, 2 bit set, 3 bit clear; d also gives the bit.
    task acc(input [1:0] k, input [5:0] a, input [7:0] d);
        @(posedge clk_sys_i);
        #1 io_addr_i = a;
        io_wdata_i = d;
        bit_sel_i = d[2:0];
        req = 4'h8 >> k;
        @(posedge clk_sys_i);
        #1 req = 4'h0;
    endtask
    task chk(input string n, input [7:0] s, input [7:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1 rst_n_i = 1;
        ext_d = 8'h3c;
        acc(0, 6'h11, 8'hf0);
        acc(0, 6'h12, 8'ha5);
        acc(0, 6'h10, 8'h00);
        chk("d dir", port_d_pin_oe_o, 8'hf0);
        chk("d pull", port_d_pullup_o, 8'h05);
        acc(1, 6'h10, 8'h00);
        chk("d level", io_rdata_o, 8'had);
        $display("port d test done");
        acc(0, 6'h1a, 8'h0e);
        acc(0, 6'h1b, 8'h0d);
        chk("a sink", {7'h0, led_sink_high_current_o}, 8'h01);
        chk("a pull", {4'h0, port_a_pullup_o}, 8'h01);
        chk("a oe", {4'h0, port_a_pin_oe_o}, 8'h0e);
        chk("a out", {4'h0, port_a_pin_o}, 8'h0d);
        acc(1, 6'h19, 8'h00);
        chk("a level", io_rdata_o, 8'h09);
        ext_b = 8'h5a;
        acc(0, 6'h07, 8'h80);
        port_b_special_en_i = 8'h0f;
        acc(1, 6'h16, 8'h00);
        chk("b pull", port_b_pullup_o, 8'hf0);
        chk("b level", io_rdata_o, 8'hfa);
        $display("port a and b test done");
        acc(2, 6'h12, 8'h06);
        acc(3, 6'h12, 8'h00);
        chk("d bits", port_d_pin_o, 8'he4);
        acc(2, 6'h20, 8'h00);
        chk("bit err", {7'h0, io_bit_err_o}, 8'h01);
        #3 rst_n_i = 0;
        #1 chk("rst dir", port_d_pin_oe_o, 8'h00);
        chk("rst a oe", {4'h0, port_a_pin_oe_o}, 8'h00);
        $display("bit and reset test done");
        stop_test;
    end
endmodule
